// ==== pkg/mrr_defs.vh ====
`ifndef MRR_DEFS_VH
`define MRR_DEFS_VH

// Register offsets in book 0, page 0
`define MRR_ADDR_BATT_HIGH      8'h2d
`define MRR_ADDR_BATT_LOW       8'h2e
`define MRR_ADDR_IRQ_DETECT     8'h26
`define MRR_ADDR_TEMP_CTRL      8'h31
`define MRR_ADDR_LOW_POWER      8'h35
`define MRR_ADDR_RATE           8'h36

// Reset values
`define MRR_RST_BATT_HIGH       8'hc0
`define MRR_RST_BATT_LOW        8'h00
`define MRR_RST_TEMP_CTRL       8'h00
`define MRR_RST_LOW_POWER       8'h00
`define MRR_RST_RATE            8'h32

// Field positions
`define MRR_BIT_DONE_FLAG       1
`define MRR_BIT_TEMP_REQ        5
`define MRR_BIT_TEMP_VALID      4
`define MRR_BIT_POR_OFF         7
`define MRR_BATT_LOW_MSB        7
`define MRR_BATT_LOW_LSB        6

// Sample rate codes
`define MRR_RATE_8K             2'h0
`define MRR_RATE_16K            2'h1
`define MRR_RATE_48K            2'h2
`define MRR_RATE_96K            2'h3

// Temperature range codes at the ends of the scale
`define MRR_TEMP_BELOW_30       4'h0
`define MRR_TEMP_ABOVE_140      4'hf

// Sensor acquisition time
`define MRR_TEMP_ACQ_US         10
`define MRR_CLK_MHZ             100
`define MRR_TEMP_ACQ_CYCLES     (`MRR_TEMP_ACQ_US * `MRR_CLK_MHZ)

`endif

// ==== hdl/mrr_sync2.v ====
`timescale 1ns/1ns
module mrr_sync2 #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_b,
    // Data
    input  wire [W-1:0] asyncIn,
    output reg  [W-1:0] syncOut
);
    reg [W-1:0] stage1;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1  <= {W{1'b0}};
            syncOut <= {W{1'b0}};
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule // mrr_sync2

// ==== hdl/mrr_temp_seq.v ====
`timescale 1ns/1ns
`include "mrr_defs.vh"
module mrr_temp_seq (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_b,
    // Control
    input  wire       start,
    input  wire [3:0] sensorCode,
    // Status
    output reg        busy,
    output reg        valid,
    output reg  [3:0] rangeCode,
    output reg        done
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ACQ  = 2'h1;
    // Count is 16 bits wide; the last count is cut from the full-width constant on purpose
    localparam [31:0] ACQ_CYCLES = `MRR_TEMP_ACQ_CYCLES;
    localparam [31:0] ACQ_LAST_W = ACQ_CYCLES - 32'h0000_0001;
    localparam [15:0] ACQ_LAST   = ACQ_LAST_W[15:0];

    reg [1:0]  state;
    reg [15:0] count;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state     <= ST_IDLE;
            count     <= 16'h0000;
            busy      <= 1'b0;
            valid     <= 1'b0;
            rangeCode <= `MRR_TEMP_BELOW_30;
            done      <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= ST_ACQ;
                        count <= 16'h0000;
                        busy  <= 1'b1;
                        valid <= 1'b0;
                    end
                end
                ST_ACQ: begin
                    if (count == ACQ_LAST) begin
                        state     <= ST_IDLE;
                        busy      <= 1'b0;
                        valid     <= 1'b1;
                        rangeCode <= sensorCode;
                        done      <= 1'b1;
                    end else begin
                        count <= count + 16'h0001;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end
endmodule // mrr_temp_seq

// ==== hdl/mrr_regs.v ====
`timescale 1ns/1ns
`include "mrr_defs.vh"
module mrr_regs (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_b,
    // Register port from the control interface, book 0 page 0
    input  wire [7:0] regAddr,
    input  wire       regWrite,
    input  wire       regRead,
    input  wire [7:0] regWdata,
    output reg  [7:0] regRdata,
    output reg        regRvalid,
    // Successive-approximation converter, asynchronous to clk
    input  wire       convEnable,
    input  wire       convDone,
    input  wire [9:0] battery_voltage_sample,
    // Die temperature sensor, asynchronous to clk
    input  wire [3:0] sensorRange,
    // Control outputs
    output reg        porMonitorEnable,
    output reg  [1:0] audio_serial_input_rate,
    output reg        converter_done_flag
);

    // Synchronised converter and sensor inputs
    wire       convEnableS;
    wire       convDoneS;
    wire [9:0] sampleS;
    wire [3:0] sensorRangeS;

    // Converter capture
    reg        convDoneD;
    wire       convEvent;
    reg  [7:0] battHigh;
    reg  [7:0] battLow;

    // Host-written registers
    reg  [7:0] lowPower;
    reg  [7:0] rateReg;
    reg  [1:0] tempReserved;

    // Register port decode
    wire       wrTemp;
    wire       wrLowPower;
    wire       wrRate;
    wire       readDetect;

    // Temperature sequencer
    wire       tempStart;
    wire       tempBusy;
    wire       tempValid;
    wire [3:0] tempCode;

    // Read images and read data
    wire [7:0] detectImage;
    wire [7:0] tempImage;
    reg  [7:0] next_rdata;

    // Reset images cut to the width of the fields they load
    localparam [7:0] RST_RATE_REG  = `MRR_RST_RATE;
    localparam [7:0] RST_LOW_POWER = `MRR_RST_LOW_POWER;
    localparam [7:0] RST_TEMP_CTRL = `MRR_RST_TEMP_CTRL;
    localparam [1:0] RST_RATE_SEL  = RST_RATE_REG[1:0];
    localparam [0:0] RST_POR_ON    = ~RST_LOW_POWER[`MRR_BIT_POR_OFF];
    localparam [1:0] RST_TEMP_RES  = RST_TEMP_CTRL[7:6];

    // True when a strobe falls on the given register offset
    function regHit;
        input       strobe;
        input [7:0] addr;
        input [7:0] offset;
        begin
            regHit = strobe && (addr == offset);
        end
    endfunction

    // Low measurement image: sample bits on top, reserved bits forced to zero
    function [7:0] battLowImage;
        input [1:0] lowBits;
        begin
            battLowImage = {lowBits, 6'h00};
        end
    endfunction

    // Status image of the temperature register
    function [7:0] tempStatus;
        input [1:0] reserved;
        input       busy;
        input       valid;
        input [3:0] code;
        begin
            tempStatus = {reserved, busy, valid, code};
        end
    endfunction

    // Detect register image: only the converter-done bit lives in this block
    function [7:0] detectStatus;
        input flag;
        begin
            detectStatus = {6'h00, flag, 1'b0};
        end
    endfunction

    // Control pair and data words pass two stages before any logic reads them;
    // the data words are only latched on the done edge, after both stages settled
    mrr_sync2 #(
        .W(2)
    ) u_sync_ctrl (
        .clk     (clk),
        .rst_b   (rst_b),
        .asyncIn ({convEnable, convDone}),
        .syncOut ({convEnableS, convDoneS})
    );

    // Converter result word, held steady by the converter around its done edge
    mrr_sync2 #(
        .W(10)
    ) u_sync_sample (
        .clk     (clk),
        .rst_b   (rst_b),
        .asyncIn (battery_voltage_sample),
        .syncOut (sampleS)
    );

    // Sensor range code, only read when an acquisition ends
    mrr_sync2 #(
        .W(4)
    ) u_sync_sensor (
        .clk     (clk),
        .rst_b   (rst_b),
        .asyncIn (sensorRange),
        .syncOut (sensorRangeS)
    );

    // Writes to the read-only offsets decode to nothing and are dropped
    assign wrTemp     = regHit(regWrite, regAddr, `MRR_ADDR_TEMP_CTRL);
    assign wrLowPower = regHit(regWrite, regAddr, `MRR_ADDR_LOW_POWER);
    assign wrRate     = regHit(regWrite, regAddr, `MRR_ADDR_RATE);
    assign readDetect = regHit(regRead, regAddr, `MRR_ADDR_IRQ_DETECT);

    // A request while an acquisition runs is ignored, not queued
    assign tempStart = wrTemp && regWdata[`MRR_BIT_TEMP_REQ] && !tempBusy;

    // The range code is taken when the acquisition ends, not at the request
    mrr_temp_seq u_temp (
        .clk        (clk),
        .rst_b      (rst_b),
        .start      (tempStart),
        .sensorCode (sensorRangeS),
        .busy       (tempBusy),
        .valid      (tempValid),
        .rangeCode  (tempCode),
        .done       ()
    );

    // A completion only counts while the converter is enabled
    assign convEvent = convDoneS && !convDoneD && convEnableS;

    // Edge detector starts at the idle level of the done input
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            convDoneD <= 1'b0;
        end else begin
            convDoneD <= convDoneS;
        end
    end

    // Both halves load on one edge; nothing ties two host reads together
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            battHigh <= `MRR_RST_BATT_HIGH;
        end else if (convEvent) begin
            battHigh <= sampleS[9:2];
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            battLow <= `MRR_RST_BATT_LOW;
        end else if (convEvent) begin
            battLow <= battLowImage(sampleS[1:0]);
        end
    end

    // Set wins over the clear-on-read so a completion is never lost
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            converter_done_flag <= 1'b0;
        end else if (convEvent) begin
            converter_done_flag <= 1'b1;
        end else if (readDetect) begin
            converter_done_flag <= 1'b0;
        end
    end

    // Reserved bits of the host registers read back as written
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lowPower <= `MRR_RST_LOW_POWER;
        end else if (wrLowPower) begin
            lowPower <= regWdata;
        end
    end

    // Only the two low bits steer the audio input; the rest are storage
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rateReg <= `MRR_RST_RATE;
        end else if (wrRate) begin
            rateReg <= regWdata;
        end
    end

    // Bits 7-6 are storage; bit 5 is a request, not a stored bit
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tempReserved <= RST_TEMP_RES;
        end else if (wrTemp) begin
            tempReserved <= regWdata[7:6];
        end
    end

    // The monitor enable and rate outputs are flops, one edge behind their register
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            porMonitorEnable <= RST_POR_ON;
        end else begin
            porMonitorEnable <= !lowPower[`MRR_BIT_POR_OFF];
        end
    end

    // The rate output resets to the same value as the register field
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            audio_serial_input_rate <= RST_RATE_SEL;
        end else begin
            audio_serial_input_rate <= rateReg[1:0];
        end
    end

    // Images of the two status registers
    assign detectImage = detectStatus(converter_done_flag);
    assign tempImage   = tempStatus(tempReserved, tempBusy, tempValid, tempCode);

    // Unmapped offsets read as zero
    always @* begin
        next_rdata = 8'h00;
        case (regAddr)
            `MRR_ADDR_BATT_HIGH: begin
                next_rdata = battHigh;
            end
            `MRR_ADDR_BATT_LOW: begin
                next_rdata = battLowImage(battLow[7:6]);
            end
            `MRR_ADDR_IRQ_DETECT: begin
                next_rdata = detectImage;
            end
            `MRR_ADDR_TEMP_CTRL: begin
                next_rdata = tempImage;
            end
            `MRR_ADDR_LOW_POWER: begin
                next_rdata = lowPower;
            end
            `MRR_ADDR_RATE: begin
                next_rdata = rateReg;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // The valid pulse lasts one cycle
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRvalid <= 1'b0;
        end else begin
            regRvalid <= regRead;
        end
    end

    // Capture only on a read so an idle bus cannot disturb the last answer
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            regRdata <= next_rdata;
        end
    end
endmodule // mrr_regs

// ==== verif/mrr_regs_properties.sv ====
`timescale 1ns/1ns
module mrr_regs_properties (
    // Clock and reset
    input wire       clk,
    input wire       rst_b,
    // Register port
    input wire [7:0] regAddr,
    input wire       regWrite,
    input wire       regRead,
    input wire [7:0] regWdata,
    input wire [7:0] regRdata,
    input wire       regRvalid,
    // Converter and sensor
    input wire       convEnable,
    input wire       convDone,
    input wire [9:0] battery_voltage_sample,
    input wire [3:0] sensorRange,
    // Control outputs
    input wire       porMonitorEnable,
    input wire [1:0] audio_serial_input_rate,
    input wire       converter_done_flag
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    wire flagRd = regRead && regAddr == 8'h26;
    sequence lpWrite;
        regWrite && regAddr == 8'h35;
    endsequence
    sequence rateWrite;
        regWrite && regAddr == 8'h36;
    endsequence
    read_answer_a: assert property (regRead |=> regRvalid)
        else $error("read not answered");
    answer_cause_a: assert property (regRvalid |-> $past(regRead))
        else $error("answer without read");
    por_follow_a: assert property (lpWrite |-> ##3 porMonitorEnable == !$past(regWdata[7], 3))
        else $error("monitor enable wrong");
    rate_follow_a: assert property (rateWrite |-> ##3 audio_serial_input_rate == $past(regWdata[1:0], 3))
        else $error("rate output wrong");
    temp_valid_a: assert property (regRvalid && $past(regAddr) == 8'h31 && regRdata[5] |-> !regRdata[4])
        else $error("valid high while busy");
    batt_low_a: assert property (regRvalid && $past(regAddr) == 8'h2e |-> regRdata[5:0] == 6'h00)
        else $error("reserved bits set");
    flag_sticky_a: assert property (converter_done_flag && !flagRd |=> converter_done_flag)
        else $error("flag lost");
    flag_cause_a: assert property ($rose(converter_done_flag) |-> $past(convDone, 2))
        else $error("flag without done");
    reset_rate_a: assert property ($rose(rst_b) |-> audio_serial_input_rate == 2'h2)
        else $error("rate reset wrong");
endmodule // mrr_regs_properties

// ==== verif/mrr_host_model.sv ====
`timescale 1ns/1ns
module mrr_host_model (
    // Clock
    input  wire       clk,
    // Register port
    output reg  [7:0] regAddr = 8'h00,
    output reg        regWrite = 1'b0,
    output reg        regRead = 1'b0,
    output reg  [7:0] regWdata = 8'h00
);
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWdata = d;
        regWrite = w;
        regRead = !w;
        @(negedge clk);
        regWrite = 1'b0;
        regRead = 1'b0;
        // Released data must not look like the last value
        regWdata = ~d;
    endtask
endmodule // mrr_host_model

// ==== verif/testbench.sv ====
`timescale 1ns/1ns
module testbench;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic [7:0] regAddr, regWdata, regRdata, d;
    logic       regWrite, regRead, regRvalid, porMonitorEnable, converter_done_flag;
    logic       convEnable = 1'b0;
    logic       convDone = 1'b0;
    logic [9:0] battery_voltage_sample = 10'h000;
    logic [9:0] last = 10'h300;
    logic [3:0] sensorRange = 4'h0;
    logic [3:0] p = 4'h0;
    logic [1:0] audio_serial_input_rate;
    logic [7:0] expQ[$];
    int         error_cnt = 0;
    int         samples_checked = 0;
    always #5 clk = ~clk;
    mrr_regs u_mrr_regs (.clk, .rst_b, .regAddr, .regWrite, .regRead, .regWdata, .regRdata,
        .regRvalid, .convEnable, .convDone, .battery_voltage_sample, .sensorRange,
        .porMonitorEnable, .audio_serial_input_rate, .converter_done_flag);
    mrr_host_model u_mrr_host_model (.clk, .regAddr, .regWrite, .regRead, .regWdata);
    task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        u_mrr_host_model.access(1'b0, a, 8'h00);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(negedge clk) begin
        if (regRvalid === 1'b1)
            check("regRdata", expQ.size() > 0 ? expQ.pop_front() : 8'hxx, regRdata);
    end
    initial begin
        d = 8'($urandom(32'h247b_1605));
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        rd(8'h2d, 8'hc0);
        rd(8'h2e, 8'h00);
        rd(8'h31, 8'h00);
        rd(8'h35, 8'h00);
        rd(8'h36, 8'h32);
        u_mrr_host_model.access(1'b1, 8'h2d, 8'hff);
        rd(8'h2d, 8'hc0);
        rd(8'h40, 8'h00);
        $display("test reset_values done");
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom());
            d[1:0] = i[1:0];
            u_mrr_host_model.access(1'b1, 8'h36, d);
            repeat (3) @(negedge clk);
            check("rate", {6'h00, i[1:0]}, {6'h00, audio_serial_input_rate});
            rd(8'h36, d);
        end
        for (int i = 1; i >= 0; i--) begin
            u_mrr_host_model.access(1'b1, 8'h35, {i[0], 7'h00});
            repeat (3) @(negedge clk);
            check("porMonitorEnable", {7'h00, ~i[0]}, {7'h00, porMonitorEnable});
        end
        $display("test rate_and_power done");
        for (int i = 0; i < 2; i++) begin
            sensorRange = i ? 4'hf : 4'($urandom());
            u_mrr_host_model.access(1'b1, 8'h31, 8'h20);
            rd(8'h31, {4'b0010, p});
            repeat (1010) @(negedge clk);
            rd(8'h31, {4'b0001, sensorRange});
            p = sensorRange;
        end
        $display("test die_temperature done");
        for (int i = 1; i >= 0; i--) begin
            convEnable = i[0];
            battery_voltage_sample = 10'($urandom());
            repeat (4) @(negedge clk);
            convDone = 1'b1;
            repeat (6) @(negedge clk);
            convDone = 1'b0;
            if (i)
                last = battery_voltage_sample;
            rd(8'h2d, last[9:2]);
            rd(8'h2e, {last[1:0], 6'h00});
            if (i) begin
                check("flag", 8'h01, {7'h00, converter_done_flag});
                rd(8'h26, 8'h02);
                @(negedge clk);
                check("flag", 8'h00, {7'h00, converter_done_flag});
            end else begin
                check("flag", 8'h00, {7'h00, converter_done_flag});
            end
        end
        $display("test battery_sample done");
        repeat (3) @(negedge clk);
        check("pending", 8'h00, 8'(expQ.size()));
        give_verdict();
    end
    initial begin
        #100000;
        error_cnt++;
        give_verdict();
    end
endmodule // testbench
bind mrr_regs mrr_regs_properties u_mrr_regs_properties (.clk, .rst_b, .regAddr, .regWrite,
    .regRead, .regWdata, .regRdata, .regRvalid, .convEnable, .convDone,
    .battery_voltage_sample, .sensorRange, .porMonitorEnable, .audio_serial_input_rate,
    .converter_done_flag);
